// File: hdl/link_supervision_restart_fsm.v
`timescale 1ns/1ps
`include "link_supervision_defines.vh"

// Contract
// - activating pstn link: establish confirm/indication unblocks pstn ports, enters pstn in-service
// - activating pstn link: release re-requests establish, signals error, stays
// - in-service: control release requests establish, starts grace timer, error, released-1
// - in-service: control reset indication is ignored entirely
// - control released-1: establishment stops grace timer, back to in-service
// - control grace expiry: stop traffic, block isdn, start extended timer, released-2
// - control released states: further release only re-requests establish
// - extended expiry: disable links, block pstn, start guard timer, forced restart
// - released-2 establishment: stop timer, start traffic, unblock isdn, launch pending restart
// - pstn in-service: release requests establish, starts grace, error, pstn released-1
// - pstn in-service: pstn reset indication is ignored
// - pstn released-1: establishment stops pstn grace timer, back to in-service
// - pstn grace expiry: block all pstn ports, pstn released-2
// - pstn released states: further release only re-requests establish
// - pstn released-2 establishment: request restart, in-service; unblock after restart completes
// - idle: peer restart forwarded to protocol fsms, both timers, restart state
// - local restart: request to common control, then protocol fsms, timers, restart
// - peer complete only while peer timer runs; stop it; finish if local done
// - local ack only while local timer runs; stop it; complete to peer; maybe finish
// - local timer expiry: error, complete to peer, finish if peer done
// - peer timer expiry: error, complete to protocol fsms, back to idle
// - no control-protocol restart; isdn block-all and unblock used instead
// - forced restart: all data links held disabled while guard timer runs
module link_supervision_restart_fsm #(
	parameter                    TICK_CYCLES        = `TICK_CYCLES,
	parameter [`TIMER_W-1:0]     CTRL_GRACE_TICKS   = `CTRL_GRACE_MS,
	parameter [`TIMER_W-1:0]     CTRL_EXT_TICKS     = `CTRL_EXTENDED_MS,
	parameter [`TIMER_W-1:0]     PSTN_GRACE_TICKS   = `PSTN_GRACE_MS,
	parameter [`TIMER_W-1:0]     GUARD_TICKS        = `RESTART_GUARD_MS,
	parameter [`TIMER_W-1:0]     LOCAL_RST_TICKS    = `LOCAL_RESTART_MS,
	parameter [`TIMER_W-1:0]     PEER_RST_TICKS     = `PEER_RESTART_MS
) (
	input  wire                  core_clk,
	input  wire                  rstn,
	input  wire                  sys_in_service,
	input  wire                  pstn_startup,
	input  wire                  ctrl_est_conf,
	input  wire                  ctrl_est_ind,
	input  wire                  ctrl_rel_ind,
	input  wire                  pstn_est_conf,
	input  wire                  pstn_est_ind,
	input  wire                  pstn_rel_ind,
	input  wire                  peer_restart_req,
	input  wire                  peer_restart_done,
	input  wire                  proto_restart_ack,
	output reg                   ctrl_est_req,
	output reg                   pstn_est_req,
	output reg                   mgmt_error,
	output reg [`ERR_SRC_W-1:0]  mgmt_error_src,
	output reg                   stop_traffic,
	output reg                   start_traffic,
	output reg                   isdn_block_all,
	output reg                   isdn_unblock,
	output reg                   pstn_block_all,
	output reg                   pstn_unblock,
	output reg                   links_disabled,
	output reg                   startup_req,
	output reg                   cc_restart_req,
	output reg                   cc_restart_done,
	output reg                   proto_restart_req,
	output reg                   proto_restart_done,
	output reg [2:0]             ctrl_state,
	output reg [2:0]             pstn_state,
	output reg [1:0]             restart_state
);

	localparam [2:0] CTRL_STARTUP     = 3'h0;
	localparam [2:0] CTRL_IN_SERVICE  = 3'h1;
	localparam [2:0] CTRL_RELEASED_1  = 3'h2;
	localparam [2:0] CTRL_RELEASED_2  = 3'h3;
	localparam [2:0] CTRL_FORCED      = 3'h4;

	localparam [2:0] PSTN_NULL        = 3'h0;
	localparam [2:0] PSTN_ACTIVATE    = 3'h1;
	localparam [2:0] PSTN_IN_SERVICE  = 3'h2;
	localparam [2:0] PSTN_RELEASED_1  = 3'h3;
	localparam [2:0] PSTN_RELEASED_2  = 3'h4;

	localparam [1:0] RST_IDLE         = 2'h0;
	localparam [1:0] RST_LAUNCH       = 2'h1;
	localparam [1:0] RST_ACTIVE       = 2'h2;

	localparam integer           TICK_LAST_I = TICK_CYCLES - 1;
	localparam [`TICK_CNT_W-1:0] TICK_LAST   = TICK_LAST_I[`TICK_CNT_W-1:0];
	localparam [`TICK_CNT_W-1:0] TICK_ONE    = {{(`TICK_CNT_W-1){1'b0}}, 1'b1};

	reg  [`TICK_CNT_W-1:0]      tick_cnt_reg;
	reg                         tick_reg;
	reg  [`NUM_TIMERS-1:0]      t_start;
	reg  [`NUM_TIMERS-1:0]      t_stop;
	wire [`NUM_TIMERS-1:0]      t_run;
	wire [`NUM_TIMERS-1:0]      t_exp;
	wire [`NUM_TIMERS*`TIMER_W-1:0] t_load;

	reg                         restart_pending_reg;
	reg                         unblock_after_reg;
	reg                         local_done_reg;
	reg                         peer_done_reg;

	reg [2:0]                   ctrl_state_next;
	reg [2:0]                   pstn_state_next;
	reg [1:0]                   restart_state_next;
	reg                         restart_pending_next;
	reg                         unblock_after_next;
	reg                         local_done_next;
	reg                         peer_done_next;
	reg                         ctrl_est_req_next;
	reg                         pstn_est_req_next;
	reg [`ERR_SRC_W-1:0]        err_src_next;
	reg                         stop_traffic_next;
	reg                         start_traffic_next;
	reg                         isdn_block_next;
	reg                         isdn_unblock_next;
	reg                         pstn_block_next;
	reg                         pstn_unblock_next;
	reg                         links_disabled_next;
	reg                         startup_req_next;
	reg                         cc_req_next;
	reg                         cc_done_next;
	reg                         proto_req_next;
	reg                         proto_done_next;

	wire ctrl_up = ctrl_est_conf | ctrl_est_ind;
	wire pstn_up = pstn_est_conf | pstn_est_ind;
	// control traffic must be running before a local restart reaches the peer
	wire ctrl_traffic_ok = (ctrl_state == CTRL_IN_SERVICE) || (ctrl_state == CTRL_RELEASED_1);

	// millisecond tick from the core clock
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= {`TICK_CNT_W{1'b0}};
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg >= TICK_LAST) begin
			tick_cnt_reg <= {`TICK_CNT_W{1'b0}};
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + TICK_ONE;
			tick_reg     <= 1'b0;
		end
	end

	assign t_load = {PEER_RST_TICKS, LOCAL_RST_TICKS, GUARD_TICKS,
		PSTN_GRACE_TICKS, CTRL_EXT_TICKS, CTRL_GRACE_TICKS};

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_TIMERS; gi = gi + 1) begin : g_timer
			supervision_timer #(
				.WIDTH    (`TIMER_W)
			) u_timer (
				.core_clk (core_clk),
				.rstn     (rstn),
				.tick     (tick_reg),
				.start    (t_start[gi]),
				.stop     (t_stop[gi]),
				.load     (t_load[gi*`TIMER_W +: `TIMER_W]),
				.running  (t_run[gi]),
				.expired  (t_exp[gi])
			);
		end
	endgenerate

	always @* begin
		ctrl_state_next      = ctrl_state;
		pstn_state_next      = pstn_state;
		restart_state_next   = restart_state;
		restart_pending_next = restart_pending_reg;
		unblock_after_next   = unblock_after_reg;
		local_done_next      = local_done_reg;
		peer_done_next       = peer_done_reg;
		links_disabled_next  = links_disabled;
		t_start              = {`NUM_TIMERS{1'b0}};
		t_stop               = {`NUM_TIMERS{1'b0}};
		ctrl_est_req_next    = 1'b0;
		pstn_est_req_next    = 1'b0;
		err_src_next         = {`ERR_SRC_W{1'b0}};
		stop_traffic_next    = 1'b0;
		start_traffic_next   = 1'b0;
		isdn_block_next      = 1'b0;
		isdn_unblock_next    = 1'b0;
		pstn_block_next      = 1'b0;
		pstn_unblock_next    = 1'b0;
		startup_req_next     = 1'b0;
		cc_req_next          = 1'b0;
		cc_done_next         = 1'b0;
		proto_req_next       = 1'b0;
		proto_done_next      = 1'b0;

		// control link supervision; link events are tested before expiries
		case (ctrl_state)
			CTRL_STARTUP: begin
				if (sys_in_service)
					ctrl_state_next = CTRL_IN_SERVICE;
			end
			CTRL_IN_SERVICE: begin
				if (ctrl_rel_ind) begin
					ctrl_est_req_next = 1'b1;
					t_start[`T_CTRL_GRACE] = 1'b1;
					err_src_next[`ERR_CTRL] = 1'b1;
					ctrl_state_next = CTRL_RELEASED_1;
				end
				// a bare establish indication here is a link reset: no action
			end
			CTRL_RELEASED_1: begin
				if (ctrl_up) begin
					t_stop[`T_CTRL_GRACE] = 1'b1;
					ctrl_state_next = CTRL_IN_SERVICE;
				end else if (ctrl_rel_ind) begin
					ctrl_est_req_next = 1'b1;
				end else if (t_exp[`T_CTRL_GRACE]) begin
					t_stop[`T_CTRL_GRACE] = 1'b1;
					stop_traffic_next = 1'b1;
					isdn_block_next = 1'b1;
					t_start[`T_CTRL_EXT] = 1'b1;
					ctrl_state_next = CTRL_RELEASED_2;
				end
			end
			CTRL_RELEASED_2: begin
				if (ctrl_up) begin
					t_stop[`T_CTRL_EXT] = 1'b1;
					start_traffic_next = 1'b1;
					isdn_unblock_next = 1'b1;
					ctrl_state_next = CTRL_IN_SERVICE;
				end else if (ctrl_rel_ind) begin
					ctrl_est_req_next = 1'b1;
				end else if (t_exp[`T_CTRL_EXT]) begin
					t_stop[`T_CTRL_EXT] = 1'b1;
					links_disabled_next = 1'b1;
					pstn_block_next = 1'b1;
					t_start[`T_GUARD] = 1'b1;
					ctrl_state_next = CTRL_FORCED;
				end
			end
			CTRL_FORCED: begin
				// link events are ignored; links stay down for the whole guard period
				if (t_exp[`T_GUARD]) begin
					t_stop[`T_GUARD] = 1'b1;
					links_disabled_next = 1'b0;
					startup_req_next = 1'b1;
					ctrl_state_next = CTRL_STARTUP;
				end
			end
			default: begin
				ctrl_state_next = CTRL_STARTUP;
			end
		endcase

		// pstn link supervision
		case (pstn_state)
			PSTN_NULL: begin
				if (pstn_startup && !links_disabled) begin
					pstn_est_req_next = 1'b1;
					pstn_state_next = PSTN_ACTIVATE;
				end
			end
			PSTN_ACTIVATE: begin
				if (pstn_up) begin
					pstn_unblock_next = 1'b1;
					pstn_state_next = PSTN_IN_SERVICE;
				end else if (pstn_rel_ind) begin
					pstn_est_req_next = 1'b1;
					err_src_next[`ERR_PSTN] = 1'b1;
				end
			end
			PSTN_IN_SERVICE: begin
				if (pstn_rel_ind) begin
					pstn_est_req_next = 1'b1;
					t_start[`T_PSTN_GRACE] = 1'b1;
					err_src_next[`ERR_PSTN] = 1'b1;
					pstn_state_next = PSTN_RELEASED_1;
				end
				// a bare establish indication here is a link reset: no action
			end
			PSTN_RELEASED_1: begin
				if (pstn_up) begin
					t_stop[`T_PSTN_GRACE] = 1'b1;
					pstn_state_next = PSTN_IN_SERVICE;
				end else if (pstn_rel_ind) begin
					pstn_est_req_next = 1'b1;
				end else if (t_exp[`T_PSTN_GRACE]) begin
					t_stop[`T_PSTN_GRACE] = 1'b1;
					pstn_block_next = 1'b1;
					pstn_state_next = PSTN_RELEASED_2;
				end
			end
			PSTN_RELEASED_2: begin
				if (pstn_up) begin
					restart_pending_next = 1'b1;
					pstn_state_next = PSTN_IN_SERVICE;
				end else if (pstn_rel_ind) begin
					pstn_est_req_next = 1'b1;
				end
			end
			default: begin
				pstn_state_next = PSTN_NULL;
			end
		endcase

		// entering forced restart drops the pstn side back to null
		if (links_disabled_next && !links_disabled) begin
			pstn_state_next = PSTN_NULL;
			t_stop[`T_PSTN_GRACE] = 1'b1;
		end

		// pstn restart sub-process
		case (restart_state)
			RST_IDLE: begin
				if (peer_restart_req) begin
					proto_req_next = 1'b1;
					t_start[`T_LOCAL_RST] = 1'b1;
					t_start[`T_PEER_RST] = 1'b1;
					local_done_next = 1'b0;
					peer_done_next = 1'b0;
					restart_state_next = RST_ACTIVE;
				end else if (restart_pending_reg && ctrl_traffic_ok) begin
					cc_req_next = 1'b1;
					restart_pending_next = 1'b0;
					unblock_after_next = 1'b1;
					restart_state_next = RST_LAUNCH;
				end
			end
			RST_LAUNCH: begin
				proto_req_next = 1'b1;
				t_start[`T_LOCAL_RST] = 1'b1;
				t_start[`T_PEER_RST] = 1'b1;
				local_done_next = 1'b0;
				peer_done_next = 1'b0;
				restart_state_next = RST_ACTIVE;
			end
			RST_ACTIVE: begin
				// further peer restart requests are dropped here
				if (peer_restart_done && t_run[`T_PEER_RST]) begin
					t_stop[`T_PEER_RST] = 1'b1;
					peer_done_next = 1'b1;
					if (local_done_reg || t_exp[`T_LOCAL_RST]) begin
						proto_done_next = 1'b1;
						restart_state_next = RST_IDLE;
					end
				end else if (proto_restart_ack && t_run[`T_LOCAL_RST]) begin
					t_stop[`T_LOCAL_RST] = 1'b1;
					cc_done_next = 1'b1;
					local_done_next = 1'b1;
					if (peer_done_reg) begin
						proto_done_next = 1'b1;
						restart_state_next = RST_IDLE;
					end
				end else if (t_exp[`T_LOCAL_RST] && !local_done_reg) begin
					err_src_next[`ERR_RESTART] = 1'b1;
					cc_done_next = 1'b1;
					local_done_next = 1'b1;
					if (peer_done_reg) begin
						proto_done_next = 1'b1;
						restart_state_next = RST_IDLE;
					end
				end else if (t_exp[`T_PEER_RST]) begin
					t_stop[`T_PEER_RST] = 1'b1;
					err_src_next[`ERR_RESTART] = 1'b1;
					proto_done_next = 1'b1;
					restart_state_next = RST_IDLE;
				end
				if (restart_state_next == RST_IDLE) begin
					t_stop[`T_LOCAL_RST] = 1'b1;
					t_stop[`T_PEER_RST] = 1'b1;
					pstn_unblock_next = pstn_unblock_next | unblock_after_reg;
					unblock_after_next = 1'b0;
				end
			end
			default: begin
				restart_state_next = RST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_state          <= CTRL_STARTUP;
			pstn_state          <= PSTN_NULL;
			restart_state       <= RST_IDLE;
			restart_pending_reg <= 1'b0;
			unblock_after_reg   <= 1'b0;
			local_done_reg      <= 1'b0;
			peer_done_reg       <= 1'b0;
			ctrl_est_req        <= 1'b0;
			pstn_est_req        <= 1'b0;
			mgmt_error          <= 1'b0;
			mgmt_error_src      <= {`ERR_SRC_W{1'b0}};
			stop_traffic        <= 1'b0;
			start_traffic       <= 1'b0;
			isdn_block_all      <= 1'b0;
			isdn_unblock        <= 1'b0;
			pstn_block_all      <= 1'b0;
			pstn_unblock        <= 1'b0;
			links_disabled      <= 1'b0;
			startup_req         <= 1'b0;
			cc_restart_req      <= 1'b0;
			cc_restart_done     <= 1'b0;
			proto_restart_req   <= 1'b0;
			proto_restart_done  <= 1'b0;
		end else begin
			ctrl_state          <= ctrl_state_next;
			pstn_state          <= pstn_state_next;
			restart_state       <= restart_state_next;
			restart_pending_reg <= restart_pending_next;
			unblock_after_reg   <= unblock_after_next;
			local_done_reg      <= local_done_next;
			peer_done_reg       <= peer_done_next;
			ctrl_est_req        <= ctrl_est_req_next;
			pstn_est_req        <= pstn_est_req_next;
			mgmt_error          <= |err_src_next;
			mgmt_error_src      <= err_src_next;
			stop_traffic        <= stop_traffic_next;
			start_traffic       <= start_traffic_next;
			isdn_block_all      <= isdn_block_next;
			isdn_unblock        <= isdn_unblock_next;
			pstn_block_all      <= pstn_block_next;
			pstn_unblock        <= pstn_unblock_next;
			links_disabled      <= links_disabled_next;
			startup_req         <= startup_req_next;
			cc_restart_req      <= cc_req_next;
			cc_restart_done     <= cc_done_next;
			proto_restart_req   <= proto_req_next;
			proto_restart_done  <= proto_done_next;
		end
	end

endmodule // link_supervision_restart_fsm

// File: hdl/link_supervision_defines.vh
`ifndef LINK_SUPERVISION_DEFINES_VH
`define LINK_SUPERVISION_DEFINES_VH

// clock and prescaler
`define CORE_CLK_NS         8
`define TICK_NS             1000000
`define TICK_CYCLES         (`TICK_NS / `CORE_CLK_NS)
`define TICK_CNT_W          17

// timer durations in milliseconds, one tick per millisecond
`define TIMER_W             17
`define CTRL_GRACE_MS       15000
`define CTRL_EXTENDED_MS    60000
`define PSTN_GRACE_MS       15000
`define RESTART_GUARD_MS    20000
`define LOCAL_RESTART_MS    100000
`define PEER_RESTART_MS     120000

// timer slots
`define NUM_TIMERS          6
`define T_CTRL_GRACE        0
`define T_CTRL_EXT          1
`define T_PSTN_GRACE        2
`define T_GUARD             3
`define T_LOCAL_RST         4
`define T_PEER_RST          5

// error source selector bits
`define ERR_SRC_W           3
`define ERR_CTRL            0
`define ERR_PSTN            1
`define ERR_RESTART         2

`endif

// File: hdl/supervision_timer.v
`timescale 1ns/1ps

module supervision_timer #(
	parameter WIDTH = 17
) (
	input  wire             core_clk,
	input  wire             rstn,
	input  wire             tick,
	input  wire             start,
	input  wire             stop,
	input  wire [WIDTH-1:0] load,
	output reg              running,
	output reg              expired
);

	reg [WIDTH-1:0] count_reg;

	// expired is held until start or stop so a lower-priority expiry is never lost
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= {WIDTH{1'b0}};
			running   <= 1'b0;
			expired   <= 1'b0;
		end else if (start) begin
			count_reg <= load;
			running   <= 1'b1;
			expired   <= 1'b0;
		end else if (stop) begin
			running   <= 1'b0;
			expired   <= 1'b0;
		end else if (running && tick) begin
			if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
				running <= 1'b0;
				expired <= 1'b1;
			end
			count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule // supervision_timer

// File: verification/supervision_checker.sv
`timescale 1ns/1ps
module supervision_checker (
	input wire       core_clk,
	input wire       rstn,
	input wire       ctrl_est_conf,
	input wire       ctrl_est_ind,
	input wire       ctrl_rel_ind,
	input wire       pstn_est_conf,
	input wire       pstn_est_ind,
	input wire       pstn_rel_ind,
	input wire       peer_restart_req,
	input wire       ctrl_est_req,
	input wire       pstn_est_req,
	input wire [2:0] mgmt_error_src,
	input wire       stop_traffic,
	input wire       start_traffic,
	input wire       isdn_block_all,
	input wire       isdn_unblock,
	input wire       pstn_block_all,
	input wire       pstn_unblock,
	input wire       links_disabled,
	input wire       cc_restart_req,
	input wire       proto_restart_req,
	input wire [2:0] ctrl_state,
	input wire [2:0] pstn_state,
	input wire [1:0] restart_state
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire c_est = ctrl_est_conf | ctrl_est_ind;
	wire p_est = pstn_est_conf | pstn_est_ind;
	sequence s_launch;
		cc_restart_req ##1 proto_restart_req && restart_state == 2'h2;
	endsequence
	sequence s_ctrl_quiet;
		!ctrl_est_req && ctrl_state == 3'h1;
	endsequence
	a_pstn_act_up: assert property (
		pstn_state == 3'h1 && p_est |=> pstn_unblock && pstn_state == 3'h2)
		else $error("pstn activation not completed");
	a_pstn_act_retry: assert property (
		pstn_state == 3'h1 && pstn_rel_ind && !p_est
		|=> pstn_est_req && mgmt_error_src[1] && pstn_state == 3'h1)
		else $error("pstn activation retry wrong");
	a_ctrl_rel_react: assert property (
		ctrl_state == 3'h1 && ctrl_rel_ind && !c_est
		|=> ctrl_est_req && mgmt_error_src[0] && ctrl_state == 3'h2)
		else $error("control release not handled");
	a_ctrl_reset_ign: assert property (
		ctrl_state == 3'h1 && ctrl_est_ind && !ctrl_rel_ind |=> s_ctrl_quiet)
		else $error("control reset not ignored");
	a_ctrl_rel1_back: assert property (
		ctrl_state == 3'h2 && c_est |=> ctrl_state == 3'h1)
		else $error("released1 did not recover");
	a_grace_lapse: assert property (
		stop_traffic |-> isdn_block_all && ctrl_state == 3'h3)
		else $error("grace expiry actions wrong");
	a_ctrl_rel_again: assert property (
		ctrl_state inside {3'h2, 3'h3} && ctrl_rel_ind && !c_est
		|=> ctrl_est_req && ctrl_state == $past(ctrl_state))
		else $error("repeat release changed state");
	a_ext_lapse: assert property (
		$rose(links_disabled) |-> pstn_block_all && ctrl_state == 3'h4)
		else $error("extended expiry actions wrong");
	a_rel2_recover: assert property (
		ctrl_state == 3'h3 && c_est
		|=> start_traffic && isdn_unblock && ctrl_state == 3'h1)
		else $error("released2 recovery wrong");
	a_pstn_rel_react: assert property (
		pstn_state == 3'h2 && pstn_rel_ind && !p_est
		|=> pstn_est_req && mgmt_error_src[1] && pstn_state == 3'h3)
		else $error("pstn release not handled");
	a_pstn_grace: assert property (
		pstn_state == 3'h4 && $past(pstn_state) == 3'h3 |-> pstn_block_all)
		else $error("pstn ports not blocked");
	a_peer_restart: assert property (
		restart_state == 2'h0 && peer_restart_req
		|=> proto_restart_req && restart_state == 2'h2)
		else $error("peer restart not forwarded");
	a_local_order: assert property (
		cc_restart_req |-> s_launch)
		else $error("local restart order wrong");
	a_forced_hold: assert property (
		ctrl_state == 3'h4 |-> links_disabled)
		else $error("links enabled while forced");
endmodule // supervision_checker

bind link_supervision_restart_fsm supervision_checker u_chk (.core_clk, .rstn,
	.ctrl_est_conf, .ctrl_est_ind, .ctrl_rel_ind, .pstn_est_conf, .pstn_est_ind,
	.pstn_rel_ind, .peer_restart_req, .ctrl_est_req, .pstn_est_req, .mgmt_error_src,
	.stop_traffic, .start_traffic, .isdn_block_all, .isdn_unblock, .pstn_block_all,
	.pstn_unblock, .links_disabled, .cc_restart_req, .proto_restart_req, .ctrl_state,
	.pstn_state, .restart_state);

// File: verification/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model (
	input  wire core_clk,
	input  wire rstn,
	input  wire link_en,
	input  wire restart_en,
	input  wire slow,
	input  wire links_disabled,
	input  wire pstn_est_req,
	input  wire cc_restart_req,
	input  wire proto_restart_req,
	output wire pstn_est_conf,
	output wire proto_restart_ack,
	output wire peer_restart_done
);
	reg [5:0] link_d;
	reg [5:0] ack_d;
	reg [7:0] peer_d;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			link_d <= 6'h00;
			ack_d  <= 6'h00;
			peer_d <= 8'h00;
		end else begin
			link_d <= {link_d[4:0], pstn_est_req & link_en & !links_disabled};
			ack_d  <= {ack_d[4:0], proto_restart_req & restart_en};
			peer_d <= {peer_d[6:0], cc_restart_req & restart_en};
		end
	end
	// a disabled link never confirms, even if asked before the shutdown
	assign pstn_est_conf     = (slow ? link_d[5] : link_d[1]) & !links_disabled;
	assign proto_restart_ack = slow ? ack_d[5] : ack_d[1];
	assign peer_restart_done = slow ? peer_d[7] : peer_d[3];
endmodule // link_partner_model

// File: verification/link_supervision_restart_fsm_tb.sv
`timescale 1ns/1ps
module link_supervision_restart_fsm_tb;
	localparam SYS = 0, PST = 1, CEC = 2, CEI = 3, CRL = 4, PEC = 5, PEI = 6, PRL = 7, PRQ = 8;
	reg        core_clk;
	reg        rstn;
	reg  [8:0] ev;
	reg        link_en, restart_en, slow;
	wire       m_conf, m_ack, m_done;
	wire       ctrl_est_req, pstn_est_req, mgmt_error, stop_traffic, start_traffic;
	wire       isdn_block_all, isdn_unblock, pstn_block_all, pstn_unblock, links_disabled;
	wire       startup_req, cc_restart_req, cc_restart_done, proto_restart_req, proto_restart_done;
	wire [2:0] mgmt_error_src, ctrl_state, pstn_state;
	wire [1:0] restart_state;
	// order matters: index is the argument of wt
	wire [7:0] watch = {cc_restart_req, pstn_unblock, proto_restart_done, cc_restart_done,
		pstn_block_all, links_disabled, stop_traffic, startup_req};
	int        n_fail = 0, compares = 0, cyc = 0;

	link_supervision_restart_fsm #(.TICK_CYCLES(4), .CTRL_GRACE_TICKS(17'h0_0003),
		.CTRL_EXT_TICKS(17'h0_0003), .PSTN_GRACE_TICKS(17'h0_0003), .GUARD_TICKS(17'h0_0003),
		.LOCAL_RST_TICKS(17'h0_0005), .PEER_RST_TICKS(17'h0_0008)) dut (.core_clk, .rstn,
		.sys_in_service(ev[SYS]), .pstn_startup(ev[PST]), .ctrl_est_conf(ev[CEC]),
		.ctrl_est_ind(ev[CEI]), .ctrl_rel_ind(ev[CRL]), .pstn_est_conf(ev[PEC] | m_conf),
		.pstn_est_ind(ev[PEI]), .pstn_rel_ind(ev[PRL]), .peer_restart_req(ev[PRQ]),
		.peer_restart_done(m_done), .proto_restart_ack(m_ack), .ctrl_est_req, .pstn_est_req,
		.mgmt_error, .mgmt_error_src, .stop_traffic, .start_traffic, .isdn_block_all,
		.isdn_unblock, .pstn_block_all, .pstn_unblock, .links_disabled, .startup_req,
		.cc_restart_req, .cc_restart_done, .proto_restart_req, .proto_restart_done,
		.ctrl_state, .pstn_state, .restart_state);

	link_partner_model peer (.core_clk, .rstn, .link_en, .restart_en, .slow, .links_disabled,
		.pstn_est_req, .cc_restart_req, .proto_restart_req, .pstn_est_conf(m_conf),
		.proto_restart_ack(m_ack), .peer_restart_done(m_done));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task summarize;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [2:0] got, input logic [2:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	task pulse(input int b);
		@(posedge core_clk);
		ev <= 9'h001 << b;
		@(posedge core_clk);
		ev <= 9'h000;
		#1;
	endtask

	// bounded wait for a watched output; timers jitter by up to one tick
	task wt(input int b);
		int i;
		i = 0;
		while (watch[b] !== 1'b1 && i < 300) begin
			@(posedge core_clk);
			#1;
			i++;
		end
		chk(watch[b], 1'b1, "awaited output");
	endtask

	task t_activate;
		pulse(SYS);
		chk(ctrl_state, 3'h1, "control up");
		pulse(PST);
		chk(pstn_est_req, 1'b1, "pstn request");
		link_en <= 1'b1;
		pulse(PRL);
		chk(pstn_est_req, 1'b1, "pstn retry");
		chk(mgmt_error_src, 3'h2, "activation error");
		chk(pstn_state, 3'h1, "still activating");
		wt(6);
		chk(pstn_state, 3'h2, "pstn in service");
		link_en <= 1'b0;
	endtask

	task t_ctrl_fail;
		pulse(CEI);
		chk(ctrl_est_req, 1'b0, "reset request");
		chk(ctrl_state, 3'h1, "reset state");
		pulse(CRL);
		chk(ctrl_est_req, 1'b1, "control request");
		chk(mgmt_error_src, 3'h1, "control error");
		chk(ctrl_state, 3'h2, "released one");
		pulse(CEC);
		chk(ctrl_state, 3'h1, "recovered");
		pulse(CRL);
		pulse(CRL);
		chk(ctrl_est_req, 1'b1, "repeat request");
		chk(mgmt_error, 1'b0, "no repeat error");
		chk(ctrl_state, 3'h2, "held released one");
		wt(1);
		chk(isdn_block_all, 1'b1, "isdn blocked");
		chk(ctrl_state, 3'h3, "released two");
		pulse(CRL);
		chk(ctrl_state, 3'h3, "held released two");
		pulse(CEI);
		chk(start_traffic & isdn_unblock, 1'b1, "traffic resumed");
		chk(ctrl_state, 3'h1, "back in service");
	endtask

	task t_pstn_fail;
		pulse(PEI);
		chk(pstn_est_req, 1'b0, "pstn reset ignored");
		pulse(PRL);
		chk(pstn_est_req, 1'b1, "pstn request");
		chk(mgmt_error_src, 3'h2, "pstn error");
		chk(pstn_state, 3'h3, "pstn released one");
		pulse(PEC);
		chk(pstn_state, 3'h2, "pstn recovered");
		pulse(PRL);
		pulse(PRL);
		chk(pstn_state, 3'h3, "pstn held one");
		wt(3);
		chk(pstn_state, 3'h4, "pstn released two");
		pulse(PRL);
		chk(pstn_est_req, 1'b1, "pstn repeat");
		chk(pstn_state, 3'h4, "pstn held two");
		restart_en <= 1'b1;
		slow <= 1'b0;
		pulse(PEI);
		chk(pstn_state, 3'h2, "pstn restored");
		wt(7);
		@(posedge core_clk);
		#1;
		chk(proto_restart_req, 1'b1, "fsms after peer");
		wt(4);
		chk(pstn_unblock, 1'b0, "unblock too early");
		chk(restart_state, 2'h2, "waiting on peer");
		wt(5);
		chk(pstn_unblock, 1'b1, "ports unblocked");
		chk(restart_state, 2'h0, "restart finished");
		restart_en <= 1'b0;
	endtask

	task t_peer_lapse;
		pulse(PRQ);
		chk(proto_restart_req, 1'b1, "peer forwarded");
		chk(restart_state, 2'h2, "restart active");
		pulse(PRQ);
		chk(proto_restart_req, 1'b0, "second peer ignored");
		wt(4);
		chk(mgmt_error_src, 3'h4, "local lapse error");
		chk(restart_state, 2'h2, "still waiting");
		wt(5);
		chk(mgmt_error_src, 3'h4, "peer lapse error");
		chk(restart_state, 2'h0, "restart abandoned");
	endtask

	task t_forced;
		pulse(CRL);
		wt(2);
		chk(pstn_block_all, 1'b1, "pstn blocked");
		chk(ctrl_state, 3'h4, "forced restart");
		pulse(CEC);
		chk(links_disabled, 1'b1, "links held down");
		wt(0);
		chk(links_disabled, 1'b0, "links released");
		chk(ctrl_state, 3'h0, "startup again");
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		rstn = 1'b0;
		ev = 9'h000;
		link_en = 1'b0;
		restart_en = 1'b0;
		slow = 1'b1;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		t_activate();
		t_ctrl_fail();
		t_pstn_fail();
		t_peer_lapse();
		t_forced();
		summarize();
	end
endmodule // link_supervision_restart_fsm_tb
